/* File: logic/sbss_pkg.sv */
// Shared constants and types of the sensor bus slave sequencer
`default_nettype none
package sbss_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int          WORD_W      = 20;
  localparam int          BODY_W      = 16;
  localparam int          CRC_W       = 4;
  localparam int          CRC_LSB     = 0;
  localparam int          CMD_LSB     = 4;
  localparam int          ADDR_LSB    = 8;
  localparam int          PA_LSB      = 12;
  localparam int          GRP_LSB     = 16;
  localparam int          CLOSE_BIT   = 18;
  localparam int          NV_BIT      = 19;
  localparam int          SHORT_LSB   = 8;
  localparam logic [3:0]  CRC_POLY    = 4'h3;
  // ----------------------------------------------------------------
  // Commands and addresses
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_INIT     = 4'hE;
  localparam logic [3:0]  CMD_REV_INIT = 4'hF;
  localparam logic [3:0]  CMD_CLEAR    = 4'hC;
  localparam logic [3:0]  ADDR_GLOBAL  = 4'h0;
  localparam logic [3:0]  ADDR_RST     = 4'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          FAULT_TEST_US  = 200;
  localparam int          FAULT_TEST_CYC = (FAULT_TEST_US * 1000) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SBSS_IDLE = 2'b01,
    SBSS_TEST = 2'b10
  } sbss_state_t;
endpackage
`default_nettype wire

/* File: logic/sbss_ft_if.sv */
// Handshake between the sequencer and the bus fault tester
`default_nettype none
interface sbss_ft_if;
  logic start;
  logic side_up;
  logic done;
  logic fault;
  modport seq    (output start, output side_up, input done, input fault);
  modport tester (input start, input side_up, output done, output fault);
endinterface
`default_nettype wire

/* File: logic/sbss_crc.sv */
// Four-bit checksum over a sixteen-bit word body
`default_nettype none
module sbss_crc #(
  parameter logic [3:0] POLY = sbss_pkg::CRC_POLY
) (
  input  wire logic [15:0] body_i,
  output logic      [3:0]  crc_o
);
  logic [3:0] stage [0:16];

  assign stage[0] = 4'h0;
  // ----------------------------------------------------------------
  // Serial division, msb first
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_bit
    assign stage[i+1] = {stage[i][2:0], 1'b0} ^
                        ((stage[i][3] ^ body_i[15-i]) ? POLY : 4'h0);
  end
  assign crc_o = stage[16];
endmodule
`default_nettype wire

/* File: logic/sbss_fault_test.sv */
// Bus fault test: pull-down on the inactive side and overvoltage watch
`default_nettype none
module sbss_fault_test #(
  parameter int TEST_CYC = sbss_pkg::FAULT_TEST_CYC
) (
  input  wire logic  sys_clk_i,
  input  wire logic  rst_b_i,
  input  wire logic  ce_i,
  sbss_ft_if.tester  ft,
  input  wire logic  downstream_over_3v_i,
  input  wire logic  upstream_over_3v_i,
  output logic       pulldown_downstream_o,
  output logic       pulldown_upstream_o
);
  localparam int CW = $clog2(TEST_CYC + 1);

  typedef struct packed {
    logic [1:0]    sync1;
    logic [1:0]    sync2;
    logic          busy;
    logic          side_up;
    logic [CW-1:0] cnt;
    logic          fault;
    logic          done;
    logic          pd_dn;
    logic          pd_up;
  } sbss_ft_state_t;

  sbss_ft_state_t q;
  sbss_ft_state_t d;

  always_comb begin
    d       = q;
    d.sync1 = {upstream_over_3v_i, downstream_over_3v_i};
    d.sync2 = q.sync1;
    d.done  = 1'b0;
    if (ft.start && !q.busy) begin
      d.busy    = 1'b1;
      d.side_up = ft.side_up;
      d.cnt     = CW'(TEST_CYC - 1);
      d.fault   = 1'b0;
      d.pd_dn   = !ft.side_up;
      d.pd_up   = ft.side_up;
    end else if (q.busy) begin
      // R9: overvoltage on inactive side
      if (q.side_up ? q.sync2[1] : q.sync2[0]) begin
        d.fault = 1'b1;
      end
      // R11: timed test window
      if (q.cnt == '0) begin
        d.busy  = 1'b0;
        d.done  = 1'b1;
        d.pd_dn = 1'b0;
        d.pd_up = 1'b0;
      end else begin
        d.cnt = q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign ft.done               = q.done;
  assign ft.fault              = q.fault;
  // R10: pull-down sink while testing
  assign pulldown_downstream_o = q.pd_dn;
  assign pulldown_upstream_o   = q.pd_up;
endmodule
`default_nettype wire

/* File: logic/sbss_seq.sv */
// Slave sequencer: frame checking, init handling, delayed responses
// Rules of the document
// R1: Response word is shifted out in the same frame as the next command.
// R2: Answer to a command is returned during the following command frame.
// R3: Master keeps at least the minimum gap between words.
// R4: A corrupted received word suppresses the response in the next frame.
// R5: Master sends an extra same-length command to fetch the pending answer.
// R6: Master then resends the command after the last good one.
// R7: Master waits for downstream device power-up before its init.
// R8: Master init timing leaves room for the bus fault test.
// R9: Fault flagged when the unconnected switch side exceeds about 3 V.
// R10: Test runs once per init, only with close request set, 11 mA sink.
// R11: Fault test window lasts about 200 microseconds.
// R12: Switch closes after test only when no fault was seen.
// R13: Test runs whether or not the address is programmed.
// R14: Loop-back chain with both sides active skips the fault test.
// R15: Init at global address sets address zero, switch stays open.
// R16: Global init neither stores nor uses write permit or close request.
// R17: After global init, commands to zero execute but give no response.
// R18: After global init, re-initialization refused until a clear command.
// R19: After reverse init, further inits ignored until clear or reset.
// R20: Close request bit of init decides switch closure, 1 requests it.
// R21: Word is bad when its four-bit checksum mismatches the computed one.
`default_nettype none
module sbss_seq #(
  parameter int TEST_CYC = sbss_pkg::FAULT_TEST_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic [19:0] rx_word_i,
  input  wire logic        rx_long_i,
  input  wire logic        rx_done_i,
  input  wire logic        rx_err_i,
  input  wire logic        loopback_i,
  input  wire logic [11:0] resp_data_i,
  input  wire logic        downstream_over_3v_i,
  input  wire logic        upstream_over_3v_i,
  output logic      [19:0] tx_word_o,
  output logic             tx_en_o,
  output logic             tx_long_o,
  output logic             exec_valid_o,
  output logic      [3:0]  exec_cmd_o,
  output logic      [7:0]  exec_data_o,
  output logic      [3:0]  address_o,
  output logic             nvm_write_permit_o,
  output logic             switch_close_request_o,
  output logic             switch_closed_o,
  output logic             bus_fault_o,
  output logic             global_mode_o,
  output logic             reverse_init_o,
  output logic             fault_test_busy_o,
  output logic             pulldown_downstream_o,
  output logic             pulldown_upstream_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sbss_pkg::sbss_state_t st;
    logic [3:0]            addr;
    logic                  nv;
    logic                  close_req;
    logic                  sw_closed;
    logic                  bf;
    logic                  locked;
    logic                  rev_done;
    logic                  global_md;
    logic [15:0]           tx_body;
    logic                  tx_en;
    logic                  tx_long;
    logic                  exec_valid;
    logic [3:0]            exec_cmd;
    logic [7:0]            exec_data;
    logic                  ft_start;
    logic                  ft_up;
  } sbss_seq_state_t;

  sbss_seq_state_t q;
  sbss_seq_state_t d;

  sbss_ft_if ft ();

  logic [15:0] rx_body;
  logic [3:0]  rx_crc;
  logic [3:0]  tx_crc;
  logic [3:0]  f_cmd;
  logic [3:0]  f_addr;
  logic [3:0]  f_pa;
  logic [1:0]  f_grp;
  logic        f_nv;
  logic        f_close;
  logic        rx_good;

  // Short words carry no data byte; leading zeros leave the checksum as is
  assign rx_body = rx_long_i ? rx_word_i[sbss_pkg::WORD_W-1:sbss_pkg::CMD_LSB]
                             : {8'h00, rx_word_i[sbss_pkg::SHORT_LSB+3:sbss_pkg::CMD_LSB]};
  assign f_cmd   = rx_word_i[sbss_pkg::CMD_LSB +: 4];
  assign f_addr  = rx_word_i[sbss_pkg::ADDR_LSB +: 4];
  assign f_pa    = rx_word_i[sbss_pkg::PA_LSB +: 4];
  assign f_grp   = rx_word_i[sbss_pkg::GRP_LSB +: 2];
  assign f_nv    = rx_word_i[sbss_pkg::NV_BIT];
  assign f_close = rx_word_i[sbss_pkg::CLOSE_BIT];

  sbss_crc u_rx_crc (
    .body_i (rx_body),
    .crc_o  (rx_crc)
  );

  sbss_crc u_tx_crc (
    .body_i (q.tx_body),
    .crc_o  (tx_crc)
  );

  sbss_fault_test #(
    .TEST_CYC (TEST_CYC)
  ) u_fault_test (
    .sys_clk_i             (sys_clk_i),
    .rst_b_i               (rst_b_i),
    .ce_i                  (ce_i),
    .ft                    (ft.tester),
    .downstream_over_3v_i  (downstream_over_3v_i),
    .upstream_over_3v_i    (upstream_over_3v_i),
    .pulldown_downstream_o (pulldown_downstream_o),
    .pulldown_upstream_o   (pulldown_upstream_o)
  );

  // R21: checksum compare
  assign rx_good = !rx_err_i && (rx_crc == rx_word_i[sbss_pkg::CRC_LSB +: 4]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic is_init;
    logic is_rev;
    logic init_ok;
    is_init      = 1'b0;
    is_rev       = 1'b0;
    init_ok      = 1'b0;
    d            = q;
    d.exec_valid = 1'b0;
    d.ft_start   = 1'b0;

    // R12: switch decision at end of test
    if (q.st == sbss_pkg::SBSS_TEST && ft.done) begin
      d.sw_closed = !ft.fault;
      d.bf        = ft.fault;
      d.st        = sbss_pkg::SBSS_IDLE;
    end

    if (rx_done_i) begin
      // R2: response prepared now, sent in the following frame
      // R4: nothing is sent after a corrupted word
      d.tx_en   = 1'b0;
      d.tx_long = rx_long_i;
      if (rx_good) begin
        is_rev  = (f_cmd == sbss_pkg::CMD_REV_INIT);
        is_init = is_rev || (f_cmd == sbss_pkg::CMD_INIT);
        // R18: locked after global init
        // R19: locked after reverse init
        init_ok = is_init && rx_long_i && !q.locked &&
                  (f_addr == sbss_pkg::ADDR_GLOBAL || f_addr == f_pa);
        if (init_ok) begin
          d.locked = 1'b1;
          if (f_pa == sbss_pkg::ADDR_GLOBAL) begin
            // R15: address zero, switch left open
            // R16: permit and close request not stored
            d.addr      = sbss_pkg::ADDR_GLOBAL;
            d.global_md = 1'b1;
            d.sw_closed = 1'b0;
          end else begin
            d.addr      = f_pa;
            d.nv        = f_nv;
            d.close_req = f_close;
            d.rev_done  = is_rev;
            // R20: close request steers the switch
            if (f_close) begin
              if (loopback_i) begin
                // R14: loop-back, no test
                d.sw_closed = 1'b1;
              end else if (q.st == sbss_pkg::SBSS_IDLE) begin
                // R10: one test per init
                // R13: programmed or not
                d.st       = sbss_pkg::SBSS_TEST;
                d.ft_start = 1'b1;
                d.ft_up    = is_rev;
                d.bf       = 1'b0;
              end
            end
          end
          d.tx_body = {f_pa, 3'b000, q.bf, f_nv, f_close, f_grp, f_pa};
          d.tx_en   = (f_addr != sbss_pkg::ADDR_GLOBAL) && (f_pa != sbss_pkg::ADDR_GLOBAL);
        end else if (!is_init && f_addr == q.addr) begin
          // R17: executed even at address zero, silent there
          d.exec_valid = 1'b1;
          d.exec_cmd   = f_cmd;
          d.exec_data  = rx_word_i[sbss_pkg::PA_LSB +: 8];
          d.tx_en      = (f_addr != sbss_pkg::ADDR_GLOBAL);
          d.tx_body    = rx_long_i ? {q.addr, resp_data_i}
                                   : {8'h00, resp_data_i[7:0]};
          if (f_cmd == sbss_pkg::CMD_CLEAR) begin
            d.addr      = sbss_pkg::ADDR_RST;
            d.nv        = 1'b0;
            d.close_req = 1'b0;
            d.sw_closed = 1'b0;
            d.bf        = 1'b0;
            d.locked    = 1'b0;
            d.rev_done  = 1'b0;
            d.global_md = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q      <= '0;
      q.st   <= sbss_pkg::SBSS_IDLE;
      q.addr <= sbss_pkg::ADDR_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ft.start   = q.ft_start;
  assign ft.side_up = q.ft_up;

  // R1: response word held for the next full-duplex frame
  assign tx_word_o              = {q.tx_body, tx_crc};
  assign tx_en_o                = q.tx_en;
  assign tx_long_o              = q.tx_long;
  assign exec_valid_o           = q.exec_valid;
  assign exec_cmd_o             = q.exec_cmd;
  assign exec_data_o            = q.exec_data;
  assign address_o              = q.addr;
  assign nvm_write_permit_o     = q.nv;
  assign switch_close_request_o = q.close_req;
  assign switch_closed_o        = q.sw_closed;
  assign bus_fault_o            = q.bf;
  assign global_mode_o          = q.global_md;
  assign reverse_init_o         = q.rev_done;
  assign fault_test_busy_o      = (q.st == sbss_pkg::SBSS_TEST);
endmodule
`default_nettype wire

/* File: tb/sbss_seq_asserts.sv */
// Port-level assertions for the sensor bus slave sequencer
`default_nettype none
module sbss_seq_asserts #(
  parameter int TEST_CYC = sbss_pkg::FAULT_TEST_CYC
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  input wire logic [19:0] rx_word_i,
  input wire logic        rx_long_i,
  input wire logic        rx_done_i,
  input wire logic        rx_err_i,
  input wire logic        loopback_i,
  input wire logic        tx_en_o,
  input wire logic        exec_valid_o,
  input wire logic [3:0]  address_o,
  input wire logic        nvm_write_permit_o,
  input wire logic        switch_close_request_o,
  input wire logic        switch_closed_o,
  input wire logic        bus_fault_o,
  input wire logic        global_mode_o,
  input wire logic        reverse_init_o,
  input wire logic        fault_test_busy_o,
  input wire logic        pulldown_downstream_o,
  input wire logic        pulldown_upstream_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // Helpers
  // --------
  wire logic        take_w = rx_done_i & ce_i;
  wire logic        pd_w   = pulldown_downstream_o | pulldown_upstream_o;
  wire logic [15:0] body_w = rx_long_i ? rx_word_i[19:4] : {8'h00, rx_word_i[11:4]};
  logic      [15:0] pd_cnt_q;
  logic      [15:0] pd_cnt_d;
  function automatic logic [3:0] f_crc(input logic [15:0] b);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ (((c[3] ^ b[i]) == 1'b1) ? sbss_pkg::CRC_POLY : 4'h0);
    end
    return c;
  endfunction
  always_comb begin
    pd_cnt_d = pd_w ? (ce_i ? pd_cnt_q + 16'h0001 : pd_cnt_q) : 16'h0000;
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pd_cnt_q <= 16'h0000;
    end else begin
      pd_cnt_q <= pd_cnt_d;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  rsp_after_take_a: assert property ($rose(tx_en_o) |-> $past(take_w))
    else $error("response enabled without a frame");
  exec_after_take_a: assert property (exec_valid_o |-> $past(take_w))
    else $error("execution without a frame");
  err_mutes_rsp_a: assert property (take_w && rx_err_i |=> !tx_en_o)
    else $error("response after framing error");
  crc_mutes_rsp_a: assert property (take_w && f_crc(body_w) != rx_word_i[3:0] |=> !tx_en_o)
    else $error("response after checksum error");
  addr0_silent_a: assert property (take_w && rx_word_i[11:8] == 4'h0 |=> !tx_en_o)
    else $error("response to address zero");
  test_length_a: assert property ($fell(pd_w) |-> pd_cnt_q == TEST_CYC)
    else $error("fault test length wrong");
  test_cause_a: assert property ($rose(pd_w) |->
    $past(take_w, 2) && $past(rx_word_i[sbss_pkg::CLOSE_BIT], 2) && !$past(loopback_i, 2))
    else $error("fault test without close request");
  switch_verdict_a: assert property ($fell(pd_w) |=> switch_closed_o != bus_fault_o)
    else $error("switch state disagrees with fault");
  inactive_side_a: assert property (pd_w |-> (pulldown_upstream_o == reverse_init_o) &&
    !(pulldown_downstream_o && pulldown_upstream_o))
    else $error("sink on wrong side");
  global_open_a: assert property (global_mode_o |-> !switch_closed_o && address_o == 4'h0 &&
    !nvm_write_permit_o && !switch_close_request_o)
    else $error("global mode state wrong");
  loop_no_test_a: assert property (take_w && loopback_i && !fault_test_busy_o |=>
    !fault_test_busy_o [*2])
    else $error("fault test in loop-back");
endmodule
bind sbss_seq sbss_seq_asserts #(.TEST_CYC(TEST_CYC)) u_asserts (
  .sys_clk_i, .rst_b_i, .ce_i, .rx_word_i, .rx_long_i, .rx_done_i, .rx_err_i, .loopback_i,
  .tx_en_o, .exec_valid_o, .address_o, .nvm_write_permit_o, .switch_close_request_o,
  .switch_closed_o, .bus_fault_o, .global_mode_o, .reverse_init_o, .fault_test_busy_o,
  .pulldown_downstream_o, .pulldown_upstream_o
);
`default_nettype wire

/* File: tb/sbss_master_model.sv */
// Bus master model issuing command frames to the sequencer
`default_nettype none
module sbss_master_model #(
  parameter int GAP_CYC = 3
) (
  input  wire logic        sys_clk_i,
  output logic      [19:0] rx_word_o,
  output logic             rx_long_o,
  output logic             rx_done_o,
  output logic             rx_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_word_o = 20'h00000;
    rx_long_o = 1'b0;
    rx_done_o = 1'b0;
    rx_err_o  = 1'b0;
  end
  function automatic logic [3:0] f_crc(input logic [15:0] b);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ (((c[3] ^ b[i]) == 1'b1) ? sbss_pkg::CRC_POLY : 4'h0);
    end
    return c;
  endfunction
  task automatic send(input logic [3:0] cmd, input logic [3:0] adr, input logic [7:0] dat,
                      input logic lng, input logic bad, input logic ferr);
    logic [15:0] body;
    body = {(lng ? dat : 8'h00), adr, cmd};
    @(negedge sys_clk_i);
    rx_word_o <= {body, f_crc(body) ^ {3'h0, bad}};
    rx_long_o <= lng;
    rx_err_o  <= ferr;
    rx_done_o <= 1'b1;
    @(negedge sys_clk_i);
    rx_done_o <= 1'b0;
    rx_err_o  <= 1'b0;
    // Released lines show the inverse
    rx_word_o <= ~rx_word_o;
    repeat (GAP_CYC) @(negedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the sensor bus slave sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCYC = 20;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i;
  logic        ce_i;
  logic [19:0] rx_word_i;
  logic        rx_long_i;
  logic        rx_done_i;
  logic        rx_err_i;
  logic        loopback_i;
  logic [11:0] resp_data_i;
  logic        downstream_over_3v_i;
  logic        upstream_over_3v_i;
  logic [19:0] tx_word_o;
  logic        tx_en_o;
  logic        tx_long_o;
  logic        exec_valid_o;
  logic [3:0]  exec_cmd_o;
  logic [7:0]  exec_data_o;
  logic [3:0]  address_o;
  logic        nvm_write_permit_o;
  logic        switch_close_request_o;
  logic        switch_closed_o;
  logic        bus_fault_o;
  logic        global_mode_o;
  logic        reverse_init_o;
  logic        fault_test_busy_o;
  logic        pulldown_downstream_o;
  logic        pulldown_upstream_o;
  int          n_mismatch;
  int          tests_run;
  int          n_exec;
  sbss_master_model u_mst (.sys_clk_i, .rx_word_o(rx_word_i), .rx_long_o(rx_long_i),
    .rx_done_o(rx_done_i), .rx_err_o(rx_err_i));
  sbss_seq #(.TEST_CYC(TCYC)) u_dut (.sys_clk_i, .rst_b_i, .ce_i, .rx_word_i, .rx_long_i,
    .rx_done_i, .rx_err_i, .loopback_i, .resp_data_i, .downstream_over_3v_i,
    .upstream_over_3v_i, .tx_word_o, .tx_en_o, .tx_long_o, .exec_valid_o, .exec_cmd_o,
    .exec_data_o, .address_o, .nvm_write_permit_o, .switch_close_request_o, .switch_closed_o,
    .bus_fault_o, .global_mode_o, .reverse_init_o, .fault_test_busy_o, .pulldown_downstream_o,
    .pulldown_upstream_o);
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (exec_valid_o === 1'b1) begin
      n_exec++;
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t ns: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_test();
    int n;
    n = 0;
    while (fault_test_busy_o !== 1'b0) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 4 * TCYC) begin
        check(1'b0, 1'b1, "test hang");
        final_report();
      end
    end
    repeat (3) @(negedge sys_clk_i);
  endtask
  task automatic t_fwd();
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'hC5, 1'b1, 1'b0, 1'b0);
    check({address_o, nvm_write_permit_o, switch_close_request_o}, 6'h17, "init");
    check(tx_en_o, 1'b0, "addr0 silent");
    check({fault_test_busy_o, pulldown_downstream_o, pulldown_upstream_o}, 3'h6, "sink");
    wait_test();
    check({switch_closed_o, bus_fault_o}, 2'h2, "closed");
  endtask
  task automatic t_answer();
    int n0;
    n0 = n_exec;
    resp_data_i = 12'h35C;
    u_mst.send(4'h1, 4'h5, 8'h00, 1'b0, 1'b0, 1'b0);
    check({tx_en_o, tx_long_o}, 2'h2, "answer on");
    check(tx_word_o, {8'h00, 8'h5C, u_mst.f_crc(16'h005C)}, "answer word");
    check(n_exec - n0, 1, "exec");
    check(exec_cmd_o, 4'h1, "exec cmd");
  endtask
  task automatic t_corrupt();
    int n0;
    n0 = n_exec;
    u_mst.send(4'h2, 4'h5, 8'h11, 1'b1, 1'b1, 1'b0);
    check(tx_en_o, 1'b0, "crc silent");
    u_mst.send(4'h2, 4'h5, 8'h11, 1'b1, 1'b0, 1'b1);
    check(tx_en_o, 1'b0, "ferr silent");
    check(n_exec - n0, 0, "no exec");
    u_mst.send(4'h2, 4'h5, 8'h11, 1'b1, 1'b0, 1'b0);
    check({tx_en_o, tx_long_o, exec_data_o}, 10'h311, "resync");
    u_mst.send(sbss_pkg::CMD_CLEAR, 4'h5, 8'h00, 1'b1, 1'b0, 1'b0);
    check({tx_en_o, address_o, switch_closed_o}, 6'h20, "clear");
  endtask
  task automatic t_rev();
    upstream_over_3v_i = 1'b1;
    u_mst.send(sbss_pkg::CMD_REV_INIT, 4'h3, 8'h43, 1'b1, 1'b0, 1'b0);
    check({reverse_init_o, pulldown_upstream_o, pulldown_downstream_o}, 3'h6, "up sink");
    check({tx_en_o, tx_word_o[19:4]}, 17'h13043, "rev answer");
    wait_test();
    check({switch_closed_o, bus_fault_o}, 2'h1, "fault open");
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'h89, 1'b1, 1'b0, 1'b0);
    check(address_o, 4'h3, "init ignored");
    upstream_over_3v_i = 1'b0;
    u_mst.send(sbss_pkg::CMD_CLEAR, 4'h3, 8'h00, 1'b1, 1'b0, 1'b0);
    check({address_o, reverse_init_o, bus_fault_o}, 6'h00, "unlocked");
  endtask
  task automatic t_loop_noclose();
    loopback_i = 1'b1;
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'h44, 1'b1, 1'b0, 1'b0);
    check({fault_test_busy_o, pulldown_downstream_o, switch_closed_o}, 3'h1, "loop");
    loopback_i = 1'b0;
    u_mst.send(sbss_pkg::CMD_CLEAR, 4'h4, 8'h00, 1'b1, 1'b0, 1'b0);
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'h06, 1'b1, 1'b0, 1'b0);
    check({address_o, fault_test_busy_o, switch_closed_o, switch_close_request_o}, 7'h30,
      "no close");
    u_mst.send(sbss_pkg::CMD_CLEAR, 4'h6, 8'h00, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_global();
    int n0;
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'hC0, 1'b1, 1'b0, 1'b0);
    check({global_mode_o, address_o, nvm_write_permit_o, switch_close_request_o,
      fault_test_busy_o, switch_closed_o}, 9'h100, "global");
    n0 = n_exec;
    u_mst.send(4'h1, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    check({tx_en_o, 5'(n_exec - n0)}, 6'h01, "silent exec");
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'h05, 1'b1, 1'b0, 1'b0);
    check({global_mode_o, address_o}, 5'h10, "reinit refused");
    u_mst.send(sbss_pkg::CMD_CLEAR, 4'h0, 8'h00, 1'b1, 1'b0, 1'b0);
    check(global_mode_o, 1'b0, "global cleared");
  endtask
  task automatic t_freeze();
    ce_i = 1'b0;
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'h07, 1'b1, 1'b0, 1'b0);
    check({address_o, global_mode_o}, 5'h00, "frozen");
    ce_i = 1'b1;
    u_mst.send(sbss_pkg::CMD_REV_INIT, 4'h0, 8'h07, 1'b1, 1'b0, 1'b0);
    check({address_o, reverse_init_o}, 5'h0F, "rev init");
    rst_b_i = 1'b0;
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    u_mst.send(sbss_pkg::CMD_INIT, 4'h0, 8'h09, 1'b1, 1'b0, 1'b0);
    check({address_o, reverse_init_o}, 5'h12, "reset unlocks");
  endtask
  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    loopback_i = 1'b0;
    resp_data_i = 12'h000;
    downstream_over_3v_i = 1'b0;
    upstream_over_3v_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    check({tx_word_o, tx_en_o, address_o, switch_closed_o, global_mode_o, fault_test_busy_o},
      28'h0, "reset");
    rst_b_i = 1'b1;
    t_fwd();
    t_answer();
    t_corrupt();
    t_rev();
    t_loop_noclose();
    t_global();
    t_freeze();
    final_report();
  end
endmodule
`default_nettype wire
